/* rtl/stc_edge_sync.sv */
// Two-flop synchroniser with registered rise and fall pulses.
// Assumes an asynchronous pin that idles at IDLE_LEVEL.
module stc_edge_sync #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pin and pulses
    input wire logic pin,
    output logic rise,
    output logic fall
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= IDLE_LEVEL;
            sync_r <= IDLE_LEVEL;
            prev_r <= IDLE_LEVEL;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
            rise <= sync_r & ~prev_r;
            fall <= ~sync_r & prev_r;
        end
    end

endmodule : stc_edge_sync

/* rtl/stc_pkg.sv */
// Constants, register map and carrier types of the sweep trigger control.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package stc_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ = 32'h0131_2D00;
    localparam int unsigned MS_PER_S = 32'h0000_03E8;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

    // Line trigger range in Hz; the shortest accepted period rounds up
    localparam int unsigned LINE_MIN_HZ = 32'h0000_0030;
    localparam int unsigned LINE_MAX_HZ = 32'h0000_01B8;
    localparam int unsigned LINE_MIN_CYC =
        (CLK_HZ + LINE_MAX_HZ - 1) / LINE_MAX_HZ;

    // Rearm interval limits in ms (25 ms to 2.4 s), sweep time floor in ms
    localparam logic [15:0] REARM_MIN_MS = 16'h0019;
    localparam logic [15:0] REARM_MAX_MS = 16'h0960;
    localparam logic [15:0] SWEEP_MIN_MS = 16'h0001;
    localparam logic [15:0] SWEEP_MAX_MS = 16'hFFFF;

    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_REARM = 8'h04;
    localparam logic [7:0] OFF_SWEEP = 8'h08;
    localparam logic [7:0] OFF_INHIBIT = 8'h0C;
    localparam logic [7:0] OFF_MARKER = 8'h10;
    localparam logic [7:0] OFF_MANUAL = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_POS = 8'h1C;

    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_MARK_BIT = 4;
    localparam int INH_CAL_BIT = 0;
    localparam int INH_PARAM_BIT = 1;

    // Reset values
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [15:0] REARM_RST = 16'h0019;
    localparam logic [15:0] SWEEP_RST = 16'h00C8;
    localparam logic [1:0] INHIBIT_RST = 2'h0;
    localparam logic [31:0] FREQ_RST = 32'h0000_0000;

    // Sweep modes and trigger sources as coded in the control register
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_MANUAL = 2'h2;
    localparam logic [1:0] SRC_FREE = 2'h0;
    localparam logic [1:0] SRC_LINE = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REARM,
        ST_ARMED,
        ST_SWEEP,
        ST_MANUAL
    } stc_state_t;

    typedef struct packed {
        logic marker_en;
        logic [1:0] src;
        logic [1:0] mode;
    } stc_ctrl_t;

    typedef struct packed {
        logic [2:0] state;
        logic sweep_active;
        logic armed;
        logic manual_prefaced;
        logic [1:0] inhibit;
    } stc_status_t;

endpackage : stc_pkg

/* rtl/stc_sweep_trigger.sv */
// Sweep sequencer and trigger selection with an AXI4-Lite register slave.
// Assumes a 20 MHz CLK_SYS, asynchronous trigger and line pins.
// How it works
// RL1 - Sweep-active output is high only while a sweep runs uninterrupted.
// RL2 - Continuous mode rearms after each sweep; next trigger starts next sweep.
// RL3 - Choosing continuous aborts and resets a running sweep, except from single.
// RL4 - Single: one trigger, one sweep, then back to start and unarmed.
// RL5 - Choosing single resets and rearms, except when coming from continuous.
// RL6 - Manual stops sweeping, enables marker, loads and prefaces manual frequency.
// RL7 - Free-run source triggers as soon as rearming ends.
// RL8 - Line source triggers at mains ticks up to 440 Hz; slower ticks are not rejected.
// RL9 - External source triggers on a falling edge of the trigger pin.
// RL10 - Triggers count only when armed; others are dropped.
// RL11 - Rearm lasts 25 ms to 2.4 s as software sets it.
// RL12 - Calibration or parameter change holds rearm and trigger acceptance.
// RL13 - One source at a time; external pin is synchronised before edge detect.
module stc_sweep_trigger #(
    parameter int unsigned MS_CYC = stc_pkg::MS_CYCLES,
    parameter int unsigned LINE_GAP_CYC = stc_pkg::LINE_MIN_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Trigger pins
    input wire logic EXTERNAL_TRIGGER_INPUT,
    input wire logic LINE_REF,
    // Sweep control
    output logic SWEEP_ACTIVE,
    output logic SWEEP_START,
    output logic SWEEP_RESET,
    output logic MARKER_ENABLE
);

    localparam logic [19:0] MS_LAST = 20'(MS_CYC - 1);
    localparam logic [19:0] LINE_GAP = 20'(LINE_GAP_CYC);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hit

    function automatic logic known(input logic [7:0] a);
        return a[7:5] == 3'h0;
    endfunction : known

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [15:0] clamp(input logic [15:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // Bus slave state
    logic aw_rdy_r;
    logic w_rdy_r;
    logic ar_rdy_r;
    logic aw_got_r;
    logic w_got_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [1:0] bresp_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // Registers and sequencer state
    stc_pkg::stc_ctrl_t ctrl_r;
    logic [15:0] rearm_ms_r;
    logic [15:0] sweep_ms_r;
    logic [1:0] inhibit_r;
    logic [31:0] marker_r;
    logic [31:0] manual_r;
    logic prefaced_r;
    stc_pkg::stc_state_t state_r;
    stc_pkg::stc_state_t state_nxt;
    logic [19:0] ms_cnt_r;
    logic [15:0] phase_r;
    logic [19:0] line_gap_r;
    logic active_r;
    logic start_r;
    logic reset_r;
    logic start_nxt;
    logic reset_nxt;

    // Write channel decode
    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic aw_got_nxt;
    logic w_got_nxt;
    logic bvalid_nxt;
    assign aw_hs = S_AXI_AWVALID & aw_rdy_r;
    assign w_hs = S_AXI_WVALID & w_rdy_r;
    assign do_wr = (aw_got_r | aw_hs) & (w_got_r | w_hs);
    assign wr_addr = aw_got_r ? awaddr_r : S_AXI_AWADDR;
    assign wr_data = w_got_r ? wdata_r : S_AXI_WDATA;
    assign wr_strb = w_got_r ? wstrb_r : S_AXI_WSTRB;
    assign aw_got_nxt = (aw_got_r | aw_hs) & ~do_wr;
    assign w_got_nxt = (w_got_r | w_hs) & ~do_wr;
    assign bvalid_nxt = do_wr | (bvalid_r & ~S_AXI_BREADY);

    // Read channel decode
    logic ar_hs;
    logic rvalid_nxt;
    logic [31:0] rd_word;
    stc_pkg::stc_status_t status;
    assign ar_hs = S_AXI_ARVALID & ar_rdy_r;
    assign rvalid_nxt = ar_hs | (rvalid_r & ~S_AXI_RREADY);
    assign status = '{state: state_r, sweep_active: active_r,
        armed: state_r == stc_pkg::ST_ARMED, manual_prefaced: prefaced_r,
        inhibit: inhibit_r};
    assign rd_word =
        hit(S_AXI_ARADDR, stc_pkg::OFF_CTRL) ? {27'h0, ctrl_r} :
        hit(S_AXI_ARADDR, stc_pkg::OFF_REARM) ? {16'h0, rearm_ms_r} :
        hit(S_AXI_ARADDR, stc_pkg::OFF_SWEEP) ? {16'h0, sweep_ms_r} :
        hit(S_AXI_ARADDR, stc_pkg::OFF_INHIBIT) ? {30'h0, inhibit_r} :
        hit(S_AXI_ARADDR, stc_pkg::OFF_MARKER) ? marker_r :
        hit(S_AXI_ARADDR, stc_pkg::OFF_MANUAL) ? manual_r :
        hit(S_AXI_ARADDR, stc_pkg::OFF_STATUS) ? {24'h0, status} :
        hit(S_AXI_ARADDR, stc_pkg::OFF_POS) ? {16'h0, phase_r} :
        32'h0000_0000;

    // Register write decode
    logic wr_ctrl;
    logic [31:0] ctrl_word;
    logic [1:0] new_mode;
    logic [1:0] new_src;
    logic press;
    logic [31:0] rearm_word;
    logic [31:0] sweep_word;
    assign wr_ctrl = do_wr & hit(wr_addr, stc_pkg::OFF_CTRL);
    assign ctrl_word = merge({27'h0, ctrl_r}, wr_data, wr_strb);
    assign new_mode = ctrl_word[stc_pkg::CTRL_MODE_LSB +: 2];
    assign new_src = ctrl_word[stc_pkg::CTRL_SRC_LSB +: 2];
    assign press = wr_ctrl & (new_mode != 2'h3);
    assign rearm_word = merge({16'h0, rearm_ms_r}, wr_data, wr_strb);
    assign sweep_word = merge({16'h0, sweep_ms_r}, wr_data, wr_strb);

    // Trigger sources
    logic ext_fall;
    logic line_rise;
    logic line_tick;
    logic trig;
    logic inhibit;
    logic ms_tick;
    logic phase_done;
    logic [15:0] phase_goal;

    stc_edge_sync #(
        .IDLE_LEVEL(1'b1)
    ) u_ext_sync (
        .clk_sys(CLK_SYS),
        .rst_n(RSTN),
        .pin(EXTERNAL_TRIGGER_INPUT),
        .rise(),
        .fall(ext_fall)
    ); // RL13

    stc_edge_sync #(
        .IDLE_LEVEL(1'b1)
    ) u_line_sync (
        .clk_sys(CLK_SYS),
        .rst_n(RSTN),
        .pin(LINE_REF),
        .rise(line_rise),
        .fall()
    );

    assign line_tick = line_rise & (line_gap_r >= LINE_GAP); // RL8
    assign trig = (ctrl_r.src == stc_pkg::SRC_FREE) | // RL7
        ((ctrl_r.src == stc_pkg::SRC_LINE) & line_tick) | // RL8
        ((ctrl_r.src == stc_pkg::SRC_EXT) & ext_fall); // RL9
    assign inhibit = |inhibit_r; // RL12
    assign ms_tick = ms_cnt_r == MS_LAST;
    assign phase_goal = (state_r == stc_pkg::ST_SWEEP) ? sweep_ms_r
        : rearm_ms_r;
    assign phase_done = ms_tick & ((phase_r + 16'h0001) >= phase_goal);

    // Sequencer next state, with mode selection taking priority
    always_comb begin
        state_nxt = state_r;
        start_nxt = 1'b0;
        reset_nxt = 1'b0;
        case (state_r)
            stc_pkg::ST_REARM: begin
                if (!inhibit && phase_done) begin
                    state_nxt = stc_pkg::ST_ARMED; // RL11
                end
            end
            stc_pkg::ST_ARMED: begin
                if (!inhibit && trig) begin
                    state_nxt = stc_pkg::ST_SWEEP; // RL10
                    start_nxt = 1'b1;
                end
            end
            stc_pkg::ST_SWEEP: begin
                if (!inhibit && phase_done) begin
                    reset_nxt = 1'b1;
                    if (ctrl_r.mode == stc_pkg::MODE_CONT) begin
                        state_nxt = stc_pkg::ST_REARM; // RL2
                    end else begin
                        state_nxt = stc_pkg::ST_IDLE; // RL4
                    end
                end
            end
            stc_pkg::ST_IDLE: begin
                state_nxt = stc_pkg::ST_IDLE;
            end
            stc_pkg::ST_MANUAL: begin
                state_nxt = stc_pkg::ST_MANUAL;
            end
            default: begin
                state_nxt = stc_pkg::ST_IDLE;
            end
        endcase
        if (press) begin
            case (new_mode)
                stc_pkg::MODE_CONT: begin
                    if (ctrl_r.mode != stc_pkg::MODE_SINGLE) begin
                        state_nxt = stc_pkg::ST_REARM; // RL3
                        start_nxt = 1'b0;
                        reset_nxt = 1'b1;
                    end else if (state_r == stc_pkg::ST_IDLE) begin
                        state_nxt = stc_pkg::ST_REARM; // RL2
                    end
                end
                stc_pkg::MODE_SINGLE: begin
                    if (ctrl_r.mode != stc_pkg::MODE_CONT) begin
                        state_nxt = stc_pkg::ST_REARM; // RL5
                        start_nxt = 1'b0;
                        reset_nxt = 1'b1;
                    end
                end
                default: begin
                    state_nxt = stc_pkg::ST_MANUAL; // RL6
                    start_nxt = 1'b0;
                end
            endcase
        end
    end

    // Bus handshake registers
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            aw_rdy_r <= 1'b0;
            w_rdy_r <= 1'b0;
            ar_rdy_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            bresp_r <= stc_pkg::RESP_OKAY;
            rresp_r <= stc_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            bvalid_r <= bvalid_nxt;
            rvalid_r <= rvalid_nxt;
            aw_rdy_r <= ~aw_got_nxt & ~bvalid_nxt;
            w_rdy_r <= ~w_got_nxt & ~bvalid_nxt;
            ar_rdy_r <= ~rvalid_nxt;
            if (aw_hs) begin
                awaddr_r <= S_AXI_AWADDR;
            end
            if (w_hs) begin
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            if (do_wr) begin
                bresp_r <= known(wr_addr) ? stc_pkg::RESP_OKAY
                    : stc_pkg::RESP_SLVERR;
            end
            if (ar_hs) begin
                rdata_r <= rd_word;
                rresp_r <= known(S_AXI_ARADDR) ? stc_pkg::RESP_OKAY
                    : stc_pkg::RESP_SLVERR;
            end
        end
    end

    // Software registers
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= stc_pkg::CTRL_RST;
            rearm_ms_r <= stc_pkg::REARM_RST;
            sweep_ms_r <= stc_pkg::SWEEP_RST;
            inhibit_r <= stc_pkg::INHIBIT_RST;
            marker_r <= stc_pkg::FREQ_RST;
            manual_r <= stc_pkg::FREQ_RST;
            prefaced_r <= 1'b0;
        end else begin
            if (press) begin
                ctrl_r.mode <= new_mode;
                prefaced_r <= new_mode == stc_pkg::MODE_MANUAL;
                if (new_mode == stc_pkg::MODE_MANUAL) begin
                    manual_r <= marker_r; // RL6
                end
            end
            if (wr_ctrl && new_src != 2'h3) begin
                ctrl_r.src <= new_src; // RL13
            end
            if (wr_ctrl) begin
                ctrl_r.marker_en <= ctrl_word[stc_pkg::CTRL_MARK_BIT] |
                    (press && new_mode == stc_pkg::MODE_MANUAL); // RL6
            end
            if (do_wr && hit(wr_addr, stc_pkg::OFF_REARM)) begin
                rearm_ms_r <= clamp(rearm_word[15:0], stc_pkg::REARM_MIN_MS,
                    stc_pkg::REARM_MAX_MS); // RL11
            end
            if (do_wr && hit(wr_addr, stc_pkg::OFF_SWEEP)) begin
                sweep_ms_r <= clamp(sweep_word[15:0], stc_pkg::SWEEP_MIN_MS,
                    stc_pkg::SWEEP_MAX_MS);
            end
            if (do_wr && hit(wr_addr, stc_pkg::OFF_INHIBIT)) begin
                inhibit_r <= wr_strb[0] ? wr_data[1:0] : inhibit_r;
            end
            if (do_wr && hit(wr_addr, stc_pkg::OFF_MARKER)) begin
                marker_r <= merge(marker_r, wr_data, wr_strb);
            end
            if (do_wr && hit(wr_addr, stc_pkg::OFF_MANUAL) && prefaced_r
                && !press) begin
                manual_r <= merge(manual_r, wr_data, wr_strb); // RL6
            end
        end
    end

    // Sequencer, timers and outputs
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= stc_pkg::ST_IDLE;
            ms_cnt_r <= 20'h00000;
            phase_r <= 16'h0000;
            line_gap_r <= 20'h00000;
            active_r <= 1'b0;
            start_r <= 1'b0;
            reset_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= start_nxt;
            reset_r <= reset_nxt;
            active_r <= (state_nxt == stc_pkg::ST_SWEEP) & ~inhibit; // RL1
            if (state_nxt != state_r || ms_tick || inhibit) begin
                ms_cnt_r <= 20'h00000; // RL12
            end else begin
                ms_cnt_r <= ms_cnt_r + 20'h00001;
            end
            if (state_nxt != state_r || reset_nxt) begin
                phase_r <= 16'h0000;
            end else if (ms_tick && !inhibit) begin
                phase_r <= phase_r + 16'h0001;
            end
            if (line_tick) begin
                line_gap_r <= 20'h00000;
            end else if (line_gap_r < LINE_GAP) begin
                line_gap_r <= line_gap_r + 20'h00001;
            end
        end
    end

    assign S_AXI_AWREADY = aw_rdy_r;
    assign S_AXI_WREADY = w_rdy_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_ARREADY = ar_rdy_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign SWEEP_ACTIVE = active_r;
    assign SWEEP_START = start_r;
    assign SWEEP_RESET = reset_r;
    assign MARKER_ENABLE = ctrl_r.marker_en;

    // Protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT};

endmodule : stc_sweep_trigger

/* verif/stc_sweep_trigger_bench.sv */
// Self-checking bench for the sweep trigger control.
// Assumes scaled counts: 20 cycles a millisecond, 40-cycle line gap.
module stc_sweep_trigger_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] r;
        logic [1:0] e;
    } stc_row_t;
    localparam logic [1:0] OK = stc_pkg::RESP_OKAY;
    localparam stc_row_t ROWS [6] = '{
        '{8'h04, 32'h0000_FFFF, 32'h0000_0960, OK},
        '{8'h04, 32'h0000_0000, 32'h0000_0019, OK},
        '{8'h08, 32'h0000_0000, 32'h0000_0001, OK},
        '{8'h10, 32'h1234_5678, 32'h1234_5678, OK},
        '{8'h18, 32'hFFFF_FFFF, 32'h0000_0000, OK},
        '{8'h24, 32'h0000_00FF, 32'h0000_0000, stc_pkg::RESP_SLVERR}};
    logic CLK_SYS = 1'h0, RSTN = 1'h0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, dat;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
    logic EXTERNAL_TRIGGER_INPUT, LINE_REF;
    logic SWEEP_ACTIVE, SWEEP_START, SWEEP_RESET, MARKER_ENABLE;
    logic fire = 1'h0, line_on = 1'h0;
    int fails = 0, total_checks = 0, n_start = 0, n_reset = 0, n, s0;

    stc_sweep_trigger #(.MS_CYC(20), .LINE_GAP_CYC(40)) i_stc_sweep_trigger
        (.*);
    stc_trig_src i_stc_trig_src (.clk_sys(CLK_SYS), .fire(fire),
        .line_on(line_on), .ext_n(EXTERNAL_TRIGGER_INPUT),
        .line_ref(LINE_REF));

    initial begin
        forever #25 CLK_SYS = !CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        if (SWEEP_START === 1'h1) n_start++;
        if (SWEEP_RESET === 1'h1) n_reset++;
    end

    task automatic chk_word(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        forever begin
            @(posedge CLK_SYS);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
            if (S_AXI_BVALID) begin
                rsp = S_AXI_BRESP;
                break;
            end
        end
        S_AXI_BREADY <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge CLK_SYS);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        forever begin
            @(posedge CLK_SYS);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
            if (S_AXI_RVALID) begin
                dat = S_AXI_RDATA;
                rsp = S_AXI_RRESP;
                break;
            end
        end
        S_AXI_RREADY <= 1'h0;
    endtask : rd
    task automatic cyc(input int k);
        repeat (k) @(posedge CLK_SYS);
        #1;
    endtask : cyc
    task automatic wait_start(input int lim);
        n = 0;
        while (SWEEP_START !== 1'h1 && n < lim) begin
            cyc(1);
            n++;
        end
    endtask : wait_start
    task automatic pull;
        @(posedge CLK_SYS);
        fire <= 1'h1;
        @(posedge CLK_SYS);
        fire <= 1'h0;
    endtask : pull
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        cyc(20000);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge CLK_SYS);
        chk_bit("active in reset", 1'h0, SWEEP_ACTIVE);
        RSTN <= 1'h1;
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].w);
            chk_word("write resp", {30'h0, ROWS[i].e}, {30'h0, rsp});
            rd(ROWS[i].a);
            chk_word("read data", ROWS[i].r, dat);
            chk_word("read resp", {30'h0, ROWS[i].e}, {30'h0, rsp});
        end
        $display("register table done");
        wr(8'h08, 32'h0000_0002);
        wr(8'h00, 32'h0000_0000);
        wait_start(900);
        chk_bit("rearm gap", 1'h1, n >= 490 && n <= 510);
        n = 0;
        while (SWEEP_ACTIVE === 1'h1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk_bit("sweep length", 1'h1, n >= 39 && n <= 41);
        wait_start(900);
        chk_bit("second sweep", 1'h1, n >= 490 && n <= 512);
        s0 = n_reset;
        wr(8'h00, 32'h0000_0000);
        cyc(2);
        chk_bit("abort active", 1'h0, SWEEP_ACTIVE);
        chk_bit("abort reset", 1'h1, n_reset > s0);
        $display("continuous test done");
        wr(8'h00, 32'h0000_000A);
        cyc(3);
        chk_bit("marker on", 1'h1, MARKER_ENABLE);
        chk_bit("manual stop", 1'h0, SWEEP_ACTIVE);
        rd(8'h14);
        chk_word("manual freq", 32'h1234_5678, dat);
        wr(8'h00, 32'h0000_0009);
        s0 = n_start;
        pull();
        cyc(30);
        chk_word("trigger in rearm", s0, n_start);
        cyc(520);
        pull();
        wait_start(10);
        chk_bit("ext fall start", 1'h1, n < 10);
        cyc(5);
        s0 = n_start;
        pull();
        cyc(10);
        chk_word("trigger in sweep", s0, n_start);
        s0 = n_reset;
        cyc(60);
        chk_bit("single reset", 1'h1, n_reset > s0);
        s0 = n_start;
        cyc(600);
        pull();
        cyc(20);
        chk_word("single unarmed", s0, n_start);
        $display("single test done");
        wr(8'h0C, 32'h0000_0001);
        wr(8'h00, 32'h0000_0009);
        cyc(700);
        pull();
        cyc(20);
        chk_word("inhibit holds", s0, n_start);
        wr(8'h0C, 32'h0000_0000);
        cyc(600);
        pull();
        wait_start(10);
        chk_bit("inhibit lifted", 1'h1, n < 10);
        cyc(80);
        $display("inhibit test done");
        wr(8'h00, 32'h0000_0005);
        line_on <= 1'h1;
        wait_start(900);
        chk_bit("line start", 1'h1, n >= 490 && n < 700);
        $display("line test done");
        wrap_up();
    end
endmodule : stc_sweep_trigger_bench

/* verif/stc_sweep_trigger_checker.sv */
// Port-level checks of the sweep trigger control.
// Assumes it is bound into the top module and sees its ports by name.
module stc_sweep_trigger_checker (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Register bus
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Sweep control
    input wire logic SWEEP_ACTIVE,
    input wire logic SWEEP_START,
    input wire logic SWEEP_RESET
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    a_start_active: assert property (SWEEP_START |-> SWEEP_ACTIVE)
        else $error("sweep start without active");
    a_start_once: assert property (SWEEP_START |=> !SWEEP_START)
        else $error("sweep start longer than a cycle");
    a_reset_stops: assert property (SWEEP_RESET |=> !SWEEP_ACTIVE)
        else $error("active after sweep reset");
    a_rearm_quiet: assert property (
        SWEEP_RESET |=> !SWEEP_START [*8])
        else $error("start during rearm");
    a_busy_drop: assert property (SWEEP_ACTIVE |=> !SWEEP_START)
        else $error("trigger taken during sweep");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
        else $error("write answer late");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer late");
    a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_write_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
endmodule : stc_sweep_trigger_checker

bind stc_sweep_trigger stc_sweep_trigger_checker i_stc_sweep_trigger_checker
    (.*);

/* verif/stc_trig_src.sv */
// Far-side model: trigger contact on the external pin and a mains tick.
// Assumes the bench asks for one trigger at a time, just after an edge.
module stc_trig_src #(
    parameter int HALF = 50
) (
    // Clock and requests
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic line_on,
    // Pins
    output logic ext_n,
    output logic line_ref
);
    int low_cnt = 0;
    int ph = 0;
    initial line_ref = 1'h0;
    // Contact to ground for four cycles, else released to the pull-up
    assign ext_n = (low_cnt == 0);
    always @(posedge clk_sys) begin
        if (fire) low_cnt <= 4;
        else if (low_cnt != 0) low_cnt <= low_cnt - 1;
        // Scaled mains square wave, still while switched off
        if (line_on) ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (line_on && ph == HALF - 1) line_ref <= !line_ref;
    end
endmodule : stc_trig_src
